/* File: src/gdfb_regs.svh */
// timing counts and field positions for the gate driver fault blocking block
// assumes a 200 MHz system clock; included by package and both ends
// Functional notes
// - external fault acts like any channel fault
// - host holds external fault over 100ns
// - host turns off opposite channel on fault
// - host dead time exceeds 2us plus reaction
// - primary undervoltage blocks both until cleared
// - secondary undervoltage blocks one channel, timed
// - collector check ignored during response time
// - after response time overvoltage trips channel
// - blocking time forces output off, status low
// - one channel fault leaves other untouched
// - blocking expiry releases channel automatically
// - short pulse turns off without soft turn-off
// - unused external fault tied inactive
// - status outputs open-drain, separate per channel
// - no reset input clears faults; here rst_i clears the fault registers
`ifndef GDFB_REGS_SVH
`define GDFB_REGS_SVH
`define GDFB_CLK_MHZ 200
`define GDFB_EXT_MIN_NS 100
`define GDFB_EXT_MIN_CYC ((`GDFB_EXT_MIN_NS * `GDFB_CLK_MHZ + 999) / 1000)
`define GDFB_DEAD_MIN_NS 2000
`define GDFB_DEAD_MIN_CYC ((`GDFB_DEAD_MIN_NS * `GDFB_CLK_MHZ + 999) / 1000)
`define GDFB_RESP_CYC 800
`define GDFB_BLOCK_CYC 20000
`define GDFB_NCH 2
`define GDFB_CH_A 0
`define GDFB_CH_B 1
`define GDFB_SYNC_VCE 0
`define GDFB_SYNC_EXT 2
`define GDFB_SYNC_SUV 4
`define GDFB_SYNC_PUV 6
`define GDFB_SYNC_W 7
`endif

/* File: src/gdfb_pkg.sv */
// types shared by the driver end and the host end
// assumes gdfb_regs.svh is on the include path
`include "gdfb_regs.svh"
package gdfb_pkg;
	typedef enum logic [1:0] {
		GDFB_IDLE = 2'b00,
		GDFB_RESP = 2'b01,
		GDFB_ON = 2'b10,
		GDFB_BLOCK = 2'b11
	} gdfb_state_t;
	typedef logic [`GDFB_NCH-1:0] gdfb_ch_t;
endpackage

/* File: src/gdfb_if.sv */
// link between host pwm controller and the gate driver fault block
// the bench resolves open-drain status wires from the enables
`timescale 1ns/1ps
`default_nettype none
interface gdfb_if;
	logic [1:0] channel_drive_in;
	logic [1:0] fault_status_n_o;
	logic [1:0] fault_status_n_oe;
	logic [1:0] fault_status_n_i;
	modport drv (input channel_drive_in, fault_status_n_i, output fault_status_n_o, fault_status_n_oe);
	modport host (output channel_drive_in, input fault_status_n_i);
endinterface
`default_nettype wire

/* File: src/gdfb_driver.sv */
// driver end: per-channel fault supervision, blocking and gate control
// assumes fault flags are asynchronous; drive inputs synchronous to sys_clk_i
// assumes the host end turns the other channel off on any status fault
// assumes the status pins are pulled up outside, since they only pull low
// assumes reset is held with the clock enable high
`timescale 1ns/1ps
`default_nettype none
`include "gdfb_regs.svh"
module gdfb_driver #(
	// response and blocking windows in enabled clock cycles, so the
	// durations follow whatever clock the system runs at
	parameter int unsigned RESP_CYC = `GDFB_RESP_CYC,
	parameter int unsigned BLOCK_CYC = `GDFB_BLOCK_CYC,
	// counter width must hold the longer of the two windows
	parameter int unsigned CW = 16
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic clk_en_i,
	gdfb_if.drv lnk,
	// fault flags arrive unsynchronised from the power stage
	input wire gdfb_pkg::gdfb_ch_t vce_over_i,
	input wire gdfb_pkg::gdfb_ch_t ext_fault_i,
	input wire gdfb_pkg::gdfb_ch_t sec_uv_i,
	input wire logic prim_uv_i,
	// gate command per channel and the soft turn-off pulse
	output logic [1:0] gate_on_o,
	output logic [1:0] soft_off_o
);
	import gdfb_pkg::*;

	// flag bundle ahead of the synchroniser; fixed bit positions per source
	// bit layout comes from the shared header so every tap agrees
	wire logic [`GDFB_SYNC_W-1:0] flag_raw;
	wire logic [`GDFB_SYNC_W-1:0] flag_sync;
	assign flag_raw[`GDFB_SYNC_VCE +: `GDFB_NCH] = vce_over_i;
	assign flag_raw[`GDFB_SYNC_EXT +: `GDFB_NCH] = ext_fault_i;
	assign flag_raw[`GDFB_SYNC_SUV +: `GDFB_NCH] = sec_uv_i;
	assign flag_raw[`GDFB_SYNC_PUV] = prim_uv_i;

	// two-flop synchroniser per flag bit; the first stage feeds only the
	// second, so a metastable first stage never reaches the channel logic
	genvar s;
	generate
		for (s = 0; s < `GDFB_SYNC_W; s++) begin : g_sync
			logic meta_r, meta_nxt, sync_r, sync_nxt;

			// both stages hold while the clock enable is low
			always_comb begin
				meta_nxt = meta_r;
				sync_nxt = sync_r;
				if (clk_en_i) begin
					meta_nxt = flag_raw[s];
					sync_nxt = meta_r;
				end
			end

			// a flag seen during reset is dropped, costing two cycles at start
			always_ff @(posedge sys_clk_i) begin
				if (rst_i) begin
					meta_r <= 1'b0;
					sync_r <= 1'b0;
				end else begin
					meta_r <= meta_nxt;
					sync_r <= sync_nxt;
				end
			end
			assign flag_sync[s] = sync_r;
		end
	endgenerate

	// primary undervoltage is shared by both channels
	wire logic puv = flag_sync[`GDFB_SYNC_PUV];

	// no fault-clear input exists; only timer expiry, rst_i or the end of primary undervoltage recovers
	wire logic [`GDFB_NCH-1:0] st_fault;
	// per-channel register copies, gathered into vectors below
	wire logic [`GDFB_NCH-1:0] gate_w;
	wire logic [`GDFB_NCH-1:0] soft_w;

	genvar g;
	generate
		for (g = 0; g < `GDFB_NCH; g++) begin : g_ch
			gdfb_state_t st_r, st_nxt;
			logic [CW-1:0] cnt_r, cnt_nxt;
			logic gate_r, gate_nxt, soft_r, soft_nxt, flt_r, flt_nxt;
			// taps of this channel only; the other channel's flags never enter
			wire logic vce = flag_sync[`GDFB_SYNC_VCE + g];
			wire logic secflt = flag_sync[`GDFB_SYNC_EXT + g] | flag_sync[`GDFB_SYNC_SUV + g];
			wire logic drv = lnk.channel_drive_in[g];

			// next state per channel; only this channel's inputs matter,
			// so a trip here never reaches the other gate or status;
			// the opposite channel is left for the host to switch off
			always_comb begin
				st_nxt = st_r;
				cnt_nxt = cnt_r;
				gate_nxt = gate_r;
				soft_nxt = 1'b0;
				flt_nxt = flt_r;
				case (st_r)
					// idle: an external or undervoltage fault trips at once, a drive starts the
					// blanking window with the gate already turned on
					GDFB_IDLE: begin
						gate_nxt = 1'b0;
						flt_nxt = 1'b0;
						// an external or undervoltage fault while idle still blocks and reports
						if (secflt) begin
							st_nxt = GDFB_BLOCK;
							cnt_nxt = CW'(BLOCK_CYC - 1);
							flt_nxt = 1'b1;
						end else if (drv && !puv) begin
							st_nxt = GDFB_RESP;
							cnt_nxt = CW'(RESP_CYC - 1);
							gate_nxt = 1'b1;
						end
					end

					// response window: count down, gate already on
					GDFB_RESP: begin
						// collector compare blanked here; external and
						// secondary undervoltage faults still trip at once
						if (secflt) begin
							st_nxt = GDFB_BLOCK;
							cnt_nxt = CW'(BLOCK_CYC - 1);
							gate_nxt = 1'b0;
							soft_nxt = 1'b1;
							flt_nxt = 1'b1;
						end else if (!drv || puv) begin
							st_nxt = GDFB_IDLE;
							gate_nxt = 1'b0;
						end else if (cnt_r == '0) begin
							st_nxt = GDFB_ON;
						end else begin
							cnt_nxt = cnt_r - 1'b1;
						end
					end

					// conducting: collector check now armed
					GDFB_ON: begin
						// soft turn-off pulse marks a fault turn-off; a normal
						// drive release takes the plain path with no pulse
						if (vce || secflt) begin
							st_nxt = GDFB_BLOCK;
							cnt_nxt = CW'(BLOCK_CYC - 1);
							gate_nxt = 1'b0;
							soft_nxt = 1'b1;
							flt_nxt = 1'b1;
						end else if (!drv || puv) begin
							st_nxt = GDFB_IDLE;
							gate_nxt = 1'b0;
						end
					end

					// blocking: drive input ignored until the counter runs out
					GDFB_BLOCK: begin
						// gate held off, status held low
						gate_nxt = 1'b0;
						flt_nxt = 1'b1;
						if (cnt_r == '0) begin
							st_nxt = GDFB_IDLE;
							flt_nxt = 1'b0;
						end else begin
							cnt_nxt = cnt_r - 1'b1;
						end
					end

					// unused code: fall back to a safe off state
					default: begin
						st_nxt = GDFB_IDLE;
						gate_nxt = 1'b0;
						flt_nxt = 1'b0;
					end
				endcase
			end

			// registers only; the enable freezes the whole channel
			always_ff @(posedge sys_clk_i) begin
				if (rst_i) begin
					st_r <= GDFB_IDLE;
					cnt_r <= '0;
					gate_r <= 1'b0;
					soft_r <= 1'b0;
					flt_r <= 1'b0;
				end else if (clk_en_i) begin
					st_r <= st_nxt;
					cnt_r <= cnt_nxt;
					gate_r <= gate_nxt;
					soft_r <= soft_nxt;
					flt_r <= flt_nxt;
				end
			end

			// channel copies for the shared output vectors
			assign gate_w[g] = gate_r;
			assign soft_w[g] = soft_r;
			// primary undervoltage reports on both channels while it lasts
			assign st_fault[g] = flt_r | puv;
		end
	endgenerate

	// primary undervoltage overrides both channels without a cycle of delay
	assign gate_on_o = gate_w & {`GDFB_NCH{~puv}};
	assign soft_off_o = soft_w;

	// open-drain status: level fixed low, only the enable moves, so a
	// shared pull-up may join both channels outside if the user wishes
	assign lnk.fault_status_n_o = '0;
	assign lnk.fault_status_n_oe = st_fault;
endmodule // gdfb_driver
`default_nettype wire

/* File: src/gdfb_host.sv */
// host end: pwm pass-through with dead time and fault cross-off
// assumes status wire is resolved high when undriven
`timescale 1ns/1ps
`default_nettype none
`include "gdfb_regs.svh"
module gdfb_host #(
	parameter int unsigned DEAD_CYC = `GDFB_DEAD_MIN_CYC + 1,
	parameter int unsigned CW = 12
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic clk_en_i,
	gdfb_if.host lnk,
	input wire gdfb_pkg::gdfb_ch_t pwm_req_i,
	output gdfb_pkg::gdfb_ch_t fault_seen_o
);
	import gdfb_pkg::*;

	gdfb_ch_t drv_r, drv_nxt, flt_r, flt_nxt;
	logic [CW-1:0] dead_r, dead_nxt;

	// dead time between channels exceeds 2us; a fault kills the other side
	always_comb begin
		flt_nxt = ~lnk.fault_status_n_i;
		dead_nxt = (dead_r != '0) ? dead_r - 1'b1 : dead_r;
		drv_nxt = drv_r;
		if (flt_nxt != 2'b00) begin
			drv_nxt = 2'b00;
			dead_nxt = CW'(DEAD_CYC);
		end else if (drv_r != 2'b00) begin
			if ((drv_r & pwm_req_i) != drv_r) begin
				drv_nxt = 2'b00;
				dead_nxt = CW'(DEAD_CYC);
			end
		end else if (dead_r == '0) begin
			if (pwm_req_i == 2'b01 || pwm_req_i == 2'b10)
				drv_nxt = pwm_req_i;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			drv_r <= 2'b00;
			flt_r <= 2'b00;
			dead_r <= CW'(DEAD_CYC);
		end else if (clk_en_i) begin
			drv_r <= drv_nxt;
			flt_r <= flt_nxt;
			dead_r <= dead_nxt;
		end
	end

	assign lnk.channel_drive_in = drv_r;
	assign fault_seen_o = flt_r;
endmodule // gdfb_host
`default_nettype wire

/* File: test/gdfb_chk.sv */
// checker on the host to driver link signals
// assumes the bench places it beside the link; clk_en_i low only while idle
`timescale 1ns/1ps
`default_nettype none
module gdfb_chk (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [1:0] channel_drive_in,
	input wire logic [1:0] fault_status_n_o,
	input wire logic [1:0] fault_status_n_oe,
	input wire logic [1:0] fault_status_n_i
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// a trip starts when the driver begins pulling its status low
	sequence s_trip_a; $rose(fault_status_n_oe[0]); endsequence
	sequence s_trip_b; $rose(fault_status_n_oe[1]); endsequence
	sequence s_drop_a; $fell(channel_drive_in[0]); endsequence
	// open drain: only the enable moves, the level stays low
	a_od_low: assert property (fault_status_n_o == 2'b00) else $error("status level not low");
	a_hold_a: assert property (s_trip_a |-> fault_status_n_oe[0] [*8]) else $error("status a dropped early");
	a_hold_b: assert property (s_trip_b |-> fault_status_n_oe[1] [*8]) else $error("status b dropped early");
	a_release_a: assert property (s_trip_a |-> ##[1:60] !fault_status_n_oe[0]) else $error("status a stuck");
	a_release_b: assert property (s_trip_b |-> ##[1:60] !fault_status_n_oe[1]) else $error("status b stuck");
	// host side: cross turn-off, never both channels, dead gap
	a_cross_off: assert property (!(&fault_status_n_i) |=> channel_drive_in == 2'b00) else $error("drive kept on fault");
	a_no_overlap: assert property (channel_drive_in != 2'b11) else $error("both channels driven");
	a_dead_gap: assert property (s_drop_a |-> !channel_drive_in[1] [*4]) else $error("dead gap too short");
endmodule // gdfb_chk
`default_nettype wire

/* File: test/gate_driver_fault_blocking_bench.sv */
// self-checking bench: driver and host joined by the link
// assumes clk_en_i high except in the final freeze check; status wires pulled up
`timescale 1ns/1ps
`default_nettype none
module gate_driver_fault_blocking_bench;
	import gdfb_pkg::*;
	localparam int BLK = 40;
	localparam int RSP = 4;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic puv = 1'b0;
	logic clk_en = 1'b1;
	// external fault inputs idle low whenever a scenario leaves them unused
	gdfb_ch_t pwm_req = '0, vce = '0, ext = '0, suv = '0;
	gdfb_ch_t seen;
	logic [1:0] gate_on, soft_off;
	logic [7:0] lfsr = 8'h09;
	int errors = 0, samples_checked = 0, cycles = 0;
	gdfb_if lnk ();
	// pull-up: wire is low only where the driver enables
	assign lnk.fault_status_n_i = ~lnk.fault_status_n_oe;
	always #2.5 sys_clk_i = ~sys_clk_i;
	gdfb_driver #(.RESP_CYC(RSP), .BLOCK_CYC(BLK)) i_gdfb_driver (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.clk_en_i(clk_en), .lnk(lnk), .vce_over_i(vce), .ext_fault_i(ext), .sec_uv_i(suv), .prim_uv_i(puv),
		.gate_on_o(gate_on), .soft_off_o(soft_off));
	gdfb_host #(.DEAD_CYC(5)) i_gdfb_host (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en), .lnk(lnk),
		.pwm_req_i(pwm_req), .fault_seen_o(seen));
	gdfb_chk i_gdfb_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .channel_drive_in(lnk.channel_drive_in),
		.fault_status_n_o(lnk.fault_status_n_o), .fault_status_n_oe(lnk.fault_status_n_oe),
		.fault_status_n_i(lnk.fault_status_n_i));
	function automatic gdfb_ch_t bit_of(input int ch);
		return gdfb_ch_t'(1 << ch);
	endfunction
	function automatic logic [7:0] lfsr_nx(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic chk(input string name, input logic [1:0] exp, input logic [1:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s exp %h got %h", name, exp, got);
		end
	endtask
	task automatic stop_test();
		if (errors == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic wait_gate(input int ch);
		for (int i = 0; i < 60 && gate_on[ch] !== 1'b1; i++) @(negedge sys_clk_i);
	endtask
	// one fault of a kind on a running channel: 0 external, 1 undervoltage, 2 collector
	task automatic trip(input int ch, input int kind);
		gdfb_ch_t b;
		b = bit_of(ch);
		pwm_req = b;
		wait_gate(ch);
		if (kind == 2) repeat (RSP + 2) @(negedge sys_clk_i);
		chk("gate_up", b, gate_on);
		case (kind)
			0: ext = b;
			1: suv = b;
			default: vce = b;
		endcase
		repeat (3) @(negedge sys_clk_i);
		chk("gate_trip", 2'b00, gate_on);
		chk("status", b, lnk.fault_status_n_oe);
		if (kind == 2) chk("soft_off", b, soft_off);
		// pulse held 22 cycles, longer than 100ns at 5ns a cycle
		repeat (19) @(negedge sys_clk_i);
		{ext, suv, vce} = '0;
		repeat (BLK - 24) @(negedge sys_clk_i);
		chk("blocked", ~b, lnk.fault_status_n_i);
		chk("gate_blk", 2'b00, gate_on);
		repeat (8) @(negedge sys_clk_i);
		chk("release", 2'b11, lnk.fault_status_n_i);
		pwm_req = '0;
		repeat (10) @(negedge sys_clk_i);
	endtask
	// hang guard well above the fewer than a thousand cycles needed
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			stop_test();
		end
	end
	initial begin
		repeat (4) @(negedge sys_clk_i);
		rst_i = 1'b0;
		repeat (8) @(negedge sys_clk_i);
		for (int k = 0; k < 6; k++) trip(k % 2, k / 2);
		for (int k = 0; k < 6; k++) begin
			lfsr = lfsr_nx(lfsr);
			trip(lfsr[0], int'(lfsr[2:1]) % 3);
		end
		// pulse ends inside the response window: no soft turn-off
		pwm_req = 2'b10;
		wait_gate(1);
		vce = 2'b10;
		@(negedge sys_clk_i);
		pwm_req = '0;
		for (int i = 0; i < 6; i++) begin
			@(negedge sys_clk_i);
			chk("no_soft", 2'b00, soft_off);
			chk("blank", 2'b00, lnk.fault_status_n_oe);
		end
		vce = '0;
		repeat (10) @(negedge sys_clk_i);
		// primary undervoltage blocks both until it clears
		pwm_req = 2'b01;
		wait_gate(0);
		puv = 1'b1;
		repeat (2) @(negedge sys_clk_i);
		chk("puv_gate", 2'b00, gate_on);
		chk("puv_stat", 2'b11, lnk.fault_status_n_oe);
		repeat (20) @(negedge sys_clk_i);
		chk("puv_hold", 2'b11, lnk.fault_status_n_oe);
		puv = 1'b0;
		pwm_req = '0;
		repeat (4) @(negedge sys_clk_i);
		chk("puv_clr", 2'b00, lnk.fault_status_n_oe);
		// clock enable low freezes both ends; nothing moves until it returns
		clk_en = 1'b0;
		pwm_req = 2'b01;
		repeat (10) @(negedge sys_clk_i);
		chk("frozen_drv", 2'b00, lnk.channel_drive_in);
		chk("frozen_gate", 2'b00, gate_on);
		clk_en = 1'b1;
		wait_gate(0);
		chk("thaw_gate", 2'b01, gate_on);
		pwm_req = '0;
		repeat (10) @(negedge sys_clk_i);
		stop_test();
	end
endmodule // gate_driver_fault_blocking_bench
`default_nettype wire
